/* src/gps_map.svh */
// register offsets, reset values and pin masks of the port block
// assumes APB byte addresses equal the sfr offsets times four
`ifndef GPS_MAP_SVH
`define GPS_MAP_SVH
`define GPS_IDX_P0_DATA 8'h80
`define GPS_IDX_P1_DATA 8'h90
`define GPS_IDX_P2_DATA 8'hA0
`define GPS_IDX_P3_DATA 8'hB0
`define GPS_IDX_P0_DIR 8'hE1
`define GPS_IDX_P1_DIR 8'hE2
`define GPS_IDX_P2_DIR 8'hE3
`define GPS_IDX_P3_DIR 8'hE4
`define GPS_IDX_P0_PU 8'hE9
`define GPS_IDX_P1_PU 8'hEA
`define GPS_IDX_P2_PU 8'hEB
`define GPS_IDX_P3_PU 8'hEC
`define GPS_IDX_P0_OTS 8'hEF
`define GPS_IDX_ALT_CTRL 8'hF0
`define GPS_IDX_RMW_CTRL 8'hF1
`define GPS_RST_BYTE 8'h00
`define GPS_MASK_P0 8'hFC
`define GPS_MASK_P1 8'hFC
`define GPS_MASK_P2 8'hFF
`define GPS_MASK_P3 8'h1F
`define GPS_MASK_OTS 8'h3C
`endif

/* src/gps_pkg.sv */
// types of the port block: per-port pin bundle and alternate function controls
// assumes gps_map.svh for all numeric values
package gps_pkg;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pu;
   } gps_pin_drv_t;
   typedef struct packed {
      logic adc_en;
      logic t1_run;
      logic t1_cnt;
      logic t0_run;
      logic t0_cnt;
      logic ex1_en;
      logic ex4_en;
      logic [3:0] ex4_sel_a;
      logic [1:0] ex4_sel_b;
      logic pwm_ch2_complement_out_en;
      logic pwm11_en;
      logic pwm01_en;
      logic pwm1_en;
      logic pwm0_en;
      logic pwm2_en;
   } gps_alt_en_t;
   typedef struct packed {
      logic pwm_ch2_complement_out;
      logic pwm11;
      logic pwm01;
      logic pwm1;
      logic pwm0;
      logic pwm2;
   } gps_pwm_t;
   typedef enum logic [1:0] {
      GPS_OWN_GPIO = 2'b00,
      GPS_OWN_DIG_IN = 2'b01,
      GPS_OWN_DIG_OUT = 2'b10,
      GPS_OWN_ANALOG = 2'b11
   } gps_own_t;
endpackage

/* src/gps_port.sv */
// four 8-bit gpio ports with alternate function sharing, apb register slave
// assumes pins arrive asynchronously and pwm levels come from peripherals
`timescale 1ns/1ns
`include "gps_map.svh"
module gps_port (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [31:0] pin_in_i,
   output gps_pkg::gps_pin_drv_t [3:0] pin_drv_o,
   input wire gps_pkg::gps_pwm_t pwm_i,
   output logic [31:0] alt_in_o
);
   // ===================================================
   // registers
   logic [7:0] data_r [0:3];
   logic [7:0] dir_r [0:3];
   logic [7:0] pu_r [0:3];
   logic [7:0] ots_r;
   gps_pkg::gps_alt_en_t alt_r;
   logic rmw_r;
   logic [31:0] sync1_r;
   logic [31:0] sync2_r;
   gps_pkg::gps_pin_drv_t [3:0] drv_r;
   logic [31:0] alt_in_r;
   logic [31:0] prdata_r;

   function automatic logic [7:0] port_mask(input logic [1:0] p);
      case (p)
         2'd0: port_mask = `GPS_MASK_P0;
         2'd1: port_mask = `GPS_MASK_P1;
         2'd2: port_mask = `GPS_MASK_P2;
         default: port_mask = `GPS_MASK_P3;
      endcase
   endfunction

   // one implemented-pin bit of a port mask
   function automatic logic mask_bit(input logic [1:0] p, input int b);
      logic [7:0] m;
      m = port_mask(p);
      mask_bit = m[b];
   endfunction

   // written byte with unimplemented bits held at zero
   function automatic logic [7:0] masked_wr(input logic [1:0] p, input logic [7:0] d);
      masked_wr = d & port_mask(p);
   endfunction

   // gpio pin drive as {out, oe, pu}; open drain drives only the low level
   function automatic logic [2:0] gpio_drv(
      input logic d,
      input logic dir,
      input logic pu,
      input logic od
   );
      logic oe;
      oe = od ? (dir && !d) : dir;
      gpio_drv = {d, oe, pu && !dir};
   endfunction

   // port read source per pin: zero, latch or synced pin
   function automatic logic rd_bit(
      input logic used,
      input gps_pkg::gps_own_t own_p,
      input logic dir,
      input logic rmw,
      input logic d,
      input logic pin
   );
      if (!used || own_p == gps_pkg::GPS_OWN_ANALOG) begin
         rd_bit = 1'b0;
      end else if (dir && own_p != gps_pkg::GPS_OWN_DIG_IN && rmw) begin
         rd_bit = d;
      end else begin
         rd_bit = pin;
      end
   endfunction

   // ===================================================
   // apb decode
   logic [7:0] idx;
   logic acc;
   logic wr;
   logic hit;
   assign idx = paddr_i[9:2];
   assign acc = psel_i && penable_i;
   assign wr = acc && pwrite_i;
   // every register answers in its first access cycle
   assign pready_o = 1'b1;
   always_comb begin
      hit = 1'b1;
      case (idx)
         `GPS_IDX_P0_DATA, `GPS_IDX_P1_DATA, `GPS_IDX_P2_DATA, `GPS_IDX_P3_DATA,
         `GPS_IDX_P0_DIR, `GPS_IDX_P1_DIR, `GPS_IDX_P2_DIR, `GPS_IDX_P3_DIR,
         `GPS_IDX_P0_PU, `GPS_IDX_P1_PU, `GPS_IDX_P2_PU, `GPS_IDX_P3_PU,
         `GPS_IDX_P0_OTS, `GPS_IDX_ALT_CTRL, `GPS_IDX_RMW_CTRL: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      if (paddr_i[11:10] != 2'b00 || paddr_i[1:0] != 2'b00) begin
         hit = 1'b0;
      end
   end
   assign pslverr_o = acc && !hit;

   // ===================================================
   // pin synchroniser
   // two stages; only the second stage is read
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sync1_r <= 32'h00000000;
         sync2_r <= 32'h00000000;
      end else begin
         sync1_r <= pin_in_i;
         sync2_r <= sync1_r;
      end
   end

   // ===================================================
   // register writes
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         for (int p = 0; p < 4; p++) begin
            data_r[p] <= `GPS_RST_BYTE;
            dir_r[p] <= `GPS_RST_BYTE;
            pu_r[p] <= `GPS_RST_BYTE;
         end
         ots_r <= `GPS_RST_BYTE;
      end else if (wr) begin
         for (int p = 0; p < 4; p++) begin
            if (idx == `GPS_IDX_P0_DATA + 8'(p * 16)) begin
               data_r[p] <= masked_wr(2'(p), pwdata_i[7:0]);
            end
            if (idx == `GPS_IDX_P0_DIR + 8'(p)) begin
               dir_r[p] <= masked_wr(2'(p), pwdata_i[7:0]);
            end
            if (idx == `GPS_IDX_P0_PU + 8'(p)) begin
               pu_r[p] <= masked_wr(2'(p), pwdata_i[7:0]);
            end
         end
         if (idx == `GPS_IDX_P0_OTS) begin
            ots_r <= pwdata_i[7:0] & `GPS_MASK_OTS;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         alt_r <= '0;
         rmw_r <= 1'b0;
      end else if (wr) begin
         if (idx == `GPS_IDX_ALT_CTRL) begin
            alt_r <= pwdata_i[$bits(gps_pkg::gps_alt_en_t)-1:0];
         end
         if (idx == `GPS_IDX_RMW_CTRL) begin
            rmw_r <= pwdata_i[0];
         end
      end
   end

   // ===================================================
   // pin ownership arbitration
   gps_pkg::gps_own_t own [0:31];
   logic [31:0] alt_out;
   logic [31:0] alt_pu;
   logic [31:0] dir_all;
   logic [31:0] in_irq_a;
   assign dir_all = {dir_r[3], dir_r[2], dir_r[1], dir_r[0]};
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         own[i] = gps_pkg::GPS_OWN_GPIO;
      end
      alt_out = 32'h00000000;
      alt_pu = 32'h00000000;
      in_irq_a = 32'h00000000;
      for (int b = 2; b < 6; b++) begin
         if (alt_r.adc_en) begin
            own[b] = gps_pkg::GPS_OWN_ANALOG;
         end
      end
      if (alt_r.t1_run && alt_r.t1_cnt) begin
         own[6] = gps_pkg::GPS_OWN_DIG_IN;
         alt_pu[6] = 1'b1;
      end
      if (alt_r.pwm_ch2_complement_out_en) begin
         own[7] = gps_pkg::GPS_OWN_DIG_OUT;
         alt_out[7] = pwm_i.pwm_ch2_complement_out;
      end else if (alt_r.ex1_en && !dir_all[7]) begin
         own[7] = gps_pkg::GPS_OWN_DIG_IN;
      end
      // port1 bits 5..2: irq group beats adc
      for (int b = 0; b < 4; b++) begin
         if (alt_r.ex4_en && alt_r.ex4_sel_a[b] && !dir_all[13-b]) begin
            own[13-b] = gps_pkg::GPS_OWN_DIG_IN;
            in_irq_a[13-b] = 1'b1;
         end else if (alt_r.adc_en) begin
            own[13-b] = gps_pkg::GPS_OWN_ANALOG;
         end
      end
      if (alt_r.t0_run && alt_r.t0_cnt) begin
         own[14] = gps_pkg::GPS_OWN_DIG_IN;
         alt_pu[14] = 1'b1;
      end
      if (alt_r.pwm11_en) begin
         own[23] = gps_pkg::GPS_OWN_DIG_OUT;
         alt_out[23] = pwm_i.pwm11;
      end else if (alt_r.ex4_en && alt_r.ex4_sel_b[1] && !dir_all[23]) begin
         own[23] = gps_pkg::GPS_OWN_DIG_IN;
      end
      if (alt_r.pwm01_en) begin
         own[22] = gps_pkg::GPS_OWN_DIG_OUT;
         alt_out[22] = pwm_i.pwm01;
      end else if (alt_r.ex4_en && alt_r.ex4_sel_b[0] && !dir_all[22]) begin
         own[22] = gps_pkg::GPS_OWN_DIG_IN;
      end
      if (alt_r.pwm1_en) begin
         own[21] = gps_pkg::GPS_OWN_DIG_OUT;
         alt_out[21] = pwm_i.pwm1;
      end
      if (alt_r.pwm0_en) begin
         own[20] = gps_pkg::GPS_OWN_DIG_OUT;
         alt_out[20] = pwm_i.pwm0;
      end
      if (alt_r.pwm2_en) begin
         own[19] = gps_pkg::GPS_OWN_DIG_OUT;
         alt_out[19] = pwm_i.pwm2;
      end
   end

   // ===================================================
   // gpio drive values, open drain on port0 bits 5..2
   logic [31:0] od_sel;
   logic [2:0] gpio_nxt [0:31];
   always_comb begin
      od_sel = 32'h00000000;
      for (int b = 2; b < 6; b++) begin
         od_sel[b] = !ots_r[b];
      end
   end

   always_comb begin
      for (int i = 0; i < 32; i++) begin
         gpio_nxt[i] = gpio_drv(data_r[i/8][i%8], dir_r[i/8][i%8], pu_r[i/8][i%8],
                                od_sel[i]);
      end
   end

   // ===================================================
   // pin drivers, registered; a function that owns the pin overrides the gpio drive
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         drv_r <= '0;
      end else begin
         for (int i = 0; i < 32; i++) begin
            case (own[i])
               gps_pkg::GPS_OWN_GPIO: begin
                  if (mask_bit(2'(i / 8), i % 8)) begin
                     drv_r[i/8].out[i%8] <= gpio_nxt[i][2];
                     drv_r[i/8].oe[i%8] <= gpio_nxt[i][1];
                     drv_r[i/8].pu[i%8] <= gpio_nxt[i][0];
                  end
               end
               // alternate output drives the pin, pull off
               gps_pkg::GPS_OWN_DIG_OUT: begin
                  drv_r[i/8].out[i%8] <= alt_out[i];
                  drv_r[i/8].oe[i%8] <= 1'b1;
                  drv_r[i/8].pu[i%8] <= 1'b0;
               end
               // owned input keeps its last pull; timer pins force it on
               gps_pkg::GPS_OWN_DIG_IN: begin
                  drv_r[i/8].oe[i%8] <= 1'b0;
                  drv_r[i/8].pu[i%8] <= alt_pu[i] | (in_irq_a[i] & 1'b0) |
                                        (drv_r[i/8].pu[i%8] & !alt_pu[i]);
               end
               gps_pkg::GPS_OWN_ANALOG: begin
                  drv_r[i/8].oe[i%8] <= 1'b0;
                  drv_r[i/8].pu[i%8] <= 1'b0;
               end
               default: begin
                  drv_r[i/8].oe[i%8] <= 1'b0;
               end
            endcase
         end
      end
   end
   assign pin_drv_o = drv_r;

   // ===================================================
   // inputs toward peripherals
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         alt_in_r <= 32'h00000000;
      end else begin
         for (int i = 0; i < 32; i++) begin
            alt_in_r[i] <= (own[i] == gps_pkg::GPS_OWN_ANALOG) ? 1'b0 : sync2_r[i];
         end
      end
   end
   assign alt_in_o = alt_in_r;

   // ===================================================
   // read path
   logic [7:0] port_rd [0:3];
   logic [31:0] rd_nxt;
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 8; b++) begin
            port_rd[p][b] = rd_bit(mask_bit(2'(p), b), own[p*8+b], dir_r[p][b], rmw_r,
                                   data_r[p][b], sync2_r[p*8+b]);
         end
      end
   end

   // register read word, zero above the low byte except for alt control, and zero for unmapped offsets
   always_comb begin
      rd_nxt = 32'h00000000;
      case (idx)
         `GPS_IDX_P0_DATA: rd_nxt[7:0] = port_rd[0];
         `GPS_IDX_P1_DATA: rd_nxt[7:0] = port_rd[1];
         `GPS_IDX_P2_DATA: rd_nxt[7:0] = port_rd[2];
         `GPS_IDX_P3_DATA: rd_nxt[7:0] = port_rd[3];
         `GPS_IDX_P0_DIR: rd_nxt[7:0] = dir_r[0];
         `GPS_IDX_P1_DIR: rd_nxt[7:0] = dir_r[1];
         `GPS_IDX_P2_DIR: rd_nxt[7:0] = dir_r[2];
         `GPS_IDX_P3_DIR: rd_nxt[7:0] = dir_r[3];
         `GPS_IDX_P0_PU: rd_nxt[7:0] = pu_r[0];
         `GPS_IDX_P1_PU: rd_nxt[7:0] = pu_r[1];
         `GPS_IDX_P2_PU: rd_nxt[7:0] = pu_r[2];
         `GPS_IDX_P3_PU: rd_nxt[7:0] = pu_r[3];
         `GPS_IDX_P0_OTS: rd_nxt[7:0] = ots_r;
         `GPS_IDX_ALT_CTRL: rd_nxt[$bits(gps_pkg::gps_alt_en_t)-1:0] = alt_r;
         `GPS_IDX_RMW_CTRL: rd_nxt[0] = rmw_r;
         default: rd_nxt = 32'h00000000;
      endcase
   end

   // captured at setup so the word stands through the access cycle
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         prdata_r <= 32'h00000000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_r <= rd_nxt;
      end
   end
   assign prdata_o = prdata_r;
endmodule // gps_port

/* tb/gps_pad_model.sv */
// pad model: each pad level from the block's driver, pull-up or bench level
// assumes bench levels stand for whatever the board drives on released pads
`timescale 1ns/1ns
module gps_pad_model (
   input wire gps_pkg::gps_pin_drv_t [3:0] drv_i,
   input wire logic [31:0] ext_i,
   output logic [31:0] pad_o
);
   // driven pad wins, else pull-up, else board level
   always_comb begin
      for (int k = 0; k < 32; k++) begin
         pad_o[k] = drv_i[k/8].oe[k%8] ? drv_i[k/8].out[k%8] : drv_i[k/8].pu[k%8] | ext_i[k];
      end
   end
endmodule // gps_pad_model

/* tb/gps_port_props.sv */
// checker of the port block: reset state, refusals, pin ownership
// assumes alt enables change only by apb writes to the alt control register
`timescale 1ns/1ns
`include "gps_map.svh"
module gps_port_props (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [31:0] pin_in_i,
   input wire gps_pkg::gps_pin_drv_t [3:0] pin_drv_o,
   input wire gps_pkg::gps_pwm_t pwm_i,
   input wire logic [31:0] alt_in_o
);
   gps_pkg::gps_alt_en_t alt_r, alt_q, alt_qq, alt_st;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // ==========
   // shadow of alt control, steady for three samples
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         alt_r <= '0;
      end else if (psel_i && penable_i && pwrite_i && paddr_i[9:2] == `GPS_IDX_ALT_CTRL) begin
         alt_r <= pwdata_i[$bits(alt_r)-1:0];
      end
   end
   always_ff @(posedge ref_clk_i) begin
      alt_q <= alt_r;
      alt_qq <= alt_q;
   end
   assign alt_st = alt_r & alt_q & alt_qq;
   // ==========
   // properties
   a_rst_clear: assert property (
      $past(srst_i) |-> pin_drv_o == '0) else $error("pins not idle after reset");
   a_unmapped_err: assert property (
      psel_i && penable_i && !paddr_i[9] |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
      else $error("unmapped access not refused");
   a_adc_owns: assert property (
      alt_st.adc_en |-> alt_in_o[5:2] == 4'h0 && pin_drv_o[0].oe[5:2] == 4'h0)
      else $error("adc pins not released");
   a_adc_port1: assert property (
      alt_st.adc_en && !alt_r.ex4_en && !alt_q.ex4_en |-> ##1 alt_in_o[13:10] == 4'h0)
      else $error("port1 adc pins read nonzero");
   a_t1_pull: assert property (
      alt_st.t1_run && alt_st.t1_cnt |-> pin_drv_o[0].pu[6] && !pin_drv_o[0].oe[6])
      else $error("timer1 pin not pulled input");
   a_t0_pull: assert property (
      alt_st.t0_run && alt_st.t0_cnt |-> pin_drv_o[1].pu[6] && !pin_drv_o[1].oe[6])
      else $error("timer0 pin not pulled input");
   a_pwm_ch2_complement_out_out: assert property (
      alt_st.pwm_ch2_complement_out_en |-> pin_drv_o[0].oe[7] && pin_drv_o[0].out[7] == $past(pwm_i.pwm_ch2_complement_out))
      else $error("pwm_ch2_complement_out not on port0 bit7");
   a_pwm11_out: assert property (
      alt_st.pwm11_en |-> pin_drv_o[2].oe[7] && pin_drv_o[2].out[7] == $past(pwm_i.pwm11))
      else $error("pwm11 not on port2 bit7");
   a_pwm2_out: assert property (
      alt_st.pwm2_en |-> pin_drv_o[2].oe[3] && pin_drv_o[2].out[3] == $past(pwm_i.pwm2))
      else $error("pwm2 not on port2 bit3");
endmodule // gps_port_props
bind gps_port gps_port_props props_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .pin_in_i(pin_in_i), .pin_drv_o(pin_drv_o), .pwm_i(pwm_i), .alt_in_o(alt_in_o));

/* tb/gps_port_tb.sv */
// testbench of the port block: apb register tests and pin ownership
// assumes pads come from gps_pad_model and pwm levels from the bench
`timescale 1ns/1ns
`include "gps_map.svh"
module gps_port_tb;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, ext = 32'h0, prdata, pin_in, alt_in, q;
   gps_pkg::gps_pwm_t pwm = '0;
   gps_pkg::gps_pin_drv_t [3:0] drv;
   gps_pkg::gps_alt_en_t alt;
   int num_errors = 0, comparisons = 0, cycles = 0;
   logic [7:0] idx [13] = '{`GPS_IDX_P0_DIR, `GPS_IDX_P1_DIR, `GPS_IDX_P2_DIR,
      `GPS_IDX_P3_DIR, `GPS_IDX_P0_PU, `GPS_IDX_P1_PU, `GPS_IDX_P2_PU, `GPS_IDX_P3_PU,
      `GPS_IDX_P0_OTS, `GPS_IDX_P0_DATA, `GPS_IDX_P1_DATA, `GPS_IDX_P2_DATA, `GPS_IDX_P3_DATA};
   logic [7:0] msk [13] = '{8'hFC, 8'hFC, 8'hFF, 8'h1F, 8'hFC, 8'hFC, 8'hFF, 8'h1F, 8'h3C,
      8'hFC, 8'hFC, 8'hFF, 8'h1F};
   always #5 ref_clk_i = ~ref_clk_i;
   gps_port dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pin_in), .pin_drv_o(drv),
      .pwm_i(pwm), .alt_in_o(alt_in));
   gps_pad_model pad_u (.drv_i(drv), .ext_i(ext), .pad_o(pin_in));
   // ==========
   // tasks
   task end_of_test;
      if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("ERROR %0t got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= d;
      @(posedge ref_clk_i);
      pen <= 1'b1;
      @(posedge ref_clk_i);
      while (pready !== 1'b1) @(posedge ref_clk_i);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task rchk(input logic [7:0] i, input logic [31:0] e);
      xfer(1'b0, i, 32'h0);
      chk(q, e);
   endtask
   // sync and register lag of the pads
   task settle;
      repeat (4) @(posedge ref_clk_i);
   endtask
   task alt_set;
      xfer(1'b1, `GPS_IDX_ALT_CTRL, 32'(alt));
      settle();
   endtask
   task do_reset;
      srst_i <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      srst_i <= 1'b0;
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   // ==========
   // sequence
   initial begin
      do_reset();
      for (int i = 0; i < 13; i++) rchk(idx[i], 32'h0);
      xfer(1'b1, `GPS_IDX_RMW_CTRL, 32'h1);
      for (int i = 0; i < 13; i++) begin
         xfer(1'b1, idx[i], 32'hFF);
         rchk(idx[i], {24'h0, msk[i]});
      end
      xfer(1'b0, 8'h10, 32'h0);
      chk({q[30:0], err}, 32'h1);
      do_reset();
      ext <= 32'h0A00_0000;
      xfer(1'b1, `GPS_IDX_P0_DIR, 32'h3C);
      xfer(1'b1, `GPS_IDX_P0_DATA, 32'h3C);
      xfer(1'b1, `GPS_IDX_P3_DATA, 32'h1F);
      settle();
      chk(drv[0].oe, 32'h0);
      rchk(`GPS_IDX_P0_DATA, 32'h0);
      xfer(1'b1, `GPS_IDX_RMW_CTRL, 32'h1);
      rchk(`GPS_IDX_P0_DATA, 32'h3C);
      rchk(`GPS_IDX_P3_DATA, 32'h0A);
      xfer(1'b1, `GPS_IDX_P0_OTS, 32'h3C);
      xfer(1'b1, `GPS_IDX_P3_PU, 32'h1F);
      settle();
      chk(drv[0].oe, 32'h3C);
      chk(drv[3].pu, 32'h1F);
      ext <= 32'hFFFF_FFFF;
      alt = '0;
      alt.adc_en = 1'b1;
      alt_set();
      rchk(`GPS_IDX_P0_DATA, 32'hC0);
      rchk(`GPS_IDX_P1_DATA, 32'hC0);
      alt.ex4_en = 1'b1;
      alt.ex4_sel_a = 4'hF;
      alt_set();
      rchk(`GPS_IDX_P1_DATA, 32'hFC);
      chk(alt_in[13:10], 32'hF);
      alt = '0;
      alt_set();
      rchk(`GPS_IDX_P0_DATA, 32'hFC);
      xfer(1'b1, `GPS_IDX_P0_DIR, 32'hFC);
      {alt.t1_run, alt.t1_cnt, alt.t0_run, alt.t0_cnt} = 4'hF;
      alt_set();
      chk({drv[0].pu[6], drv[0].oe[6], drv[1].pu[6]}, 32'h5);
      pwm <= '1;
      xfer(1'b1, `GPS_IDX_P2_DIR, 32'hFF);
      alt = '0;
      {alt.pwm_ch2_complement_out_en, alt.pwm11_en, alt.pwm01_en, alt.pwm1_en, alt.pwm0_en, alt.pwm2_en} = 6'h3F;
      alt_set();
      xfer(1'b1, `GPS_IDX_P2_DATA, 32'h07);
      xfer(1'b1, `GPS_IDX_P2_DIR, 32'h0F);
      settle();
      chk(drv[2].out[7:3], 32'h1F);
      chk(drv[2].oe[7:3], 32'h1F);
      chk(drv[0].out[7], 32'h1);
      alt = '0;
      alt_set();
      chk(drv[2].oe, 32'h0F);
      chk(drv[2].out, 32'h07);
      end_of_test();
   end
endmodule // gps_port_tb
